/* hdl/mra_consts.svh */
// Register map, field positions, reset values and limits of the multiplier result block.
// Assumes inclusion by bare name from every file that needs a number.
`ifndef MRA_CONSTS_SVH
`define MRA_CONSTS_SVH
`define MRA_OFS_MODE     12'h000
`define MRA_OFS_ARITH    12'h004
`define MRA_OFS_STICKY   12'h008
`define MRA_BIT_BANK     10
`define MRA_BIT_CHOP     15
`define MRA_BIT_SHORT    16
`define MRA_BIT_NEG      6
`define MRA_BIT_OVF      7
`define MRA_BIT_UNF      8
`define MRA_BIT_INV      9
`define MRA_BIT_FXOVF    6
`define MRA_BIT_FLOVF    7
`define MRA_MODE_MASK    32'h0001_8400
`define MRA_FLAG_MASK    32'h0000_03c0
`define MRA_MODE_RST     32'h0000_0000
`define MRA_ARITH_RST    32'h0000_0000
`define MRA_STICKY_RST   32'h0000_0000
`define MRA_SF_POS       80'h0000_7fff_ffff_ffff_ffff
`define MRA_SF_NEG       80'hffff_8000_0000_0000_0000
`define MRA_SI_POS       80'h0000_0000_0000_7fff_ffff
`define MRA_SI_NEG       80'hffff_ffff_ffff_8000_0000
`define MRA_UF_MAX       80'h0000_ffff_ffff_ffff_ffff
`define MRA_UI_MAX       80'h0000_0000_0000_ffff_ffff
`define MRA_RND_HALF     80'h0000_0000_0000_8000_0000
`define MRA_FP_EMAX      11'sd127
`define MRA_FP_EMIN      -11'sd126
`define MRA_FP_BIAS2     11'sd254
`define MRA_FP_BIAS      11'sd127
`endif

/* hdl/mra_pkg.sv */
// Types shared by the multiplier result block and its float product unit.
// Assumes nothing beyond a SystemVerilog compiler.
package mra_pkg;
    typedef enum logic [3:0] {
        MRA_OP_NOP  = 4'h0,
        MRA_OP_MUL  = 4'h1,
        MRA_OP_MACA = 4'h2,
        MRA_OP_MACS = 4'h3,
        MRA_OP_SAT  = 4'h4,
        MRA_OP_RND  = 4'h5,
        MRA_OP_CLR  = 4'h6,
        MRA_OP_WRP  = 4'h7,
        MRA_OP_RDP  = 4'h8,
        MRA_OP_FMUL = 4'h9
    } mra_op_t;
    typedef enum logic [1:0] {
        MRA_PART_LO = 2'h0,
        MRA_PART_UP = 2'h1,
        MRA_PART_OV = 2'h2
    } mra_part_t;
    typedef struct packed {
        logic inv;
        logic unf;
        logic ovf;
        logic neg;
    } mra_flags_t;
endpackage

/* hdl/mra_fpmul_if.sv */
// Carrier between the result block and its float product unit.
// Purely combinational signals; the owner clocks the results.
interface mra_fpmul_if;
    logic [39:0]          a;
    logic [39:0]          b;
    logic                 chop;
    logic                 short_fmt;
    logic [39:0]          res;
    mra_pkg::mra_flags_t  flg;
    modport req  (output a, b, chop, short_fmt, input res, flg);
    modport unit (input a, b, chop, short_fmt, output res, flg);
endinterface

/* hdl/mra_fpmul.sv */
// Float product with rounding mode, rounding boundary and flag derivation.
// Combinational; the caller registers result and flags.
`include "mra_consts.svh"
module mra_fpmul (
    mra_fpmul_if.unit fp
);
    logic [39:0]        a;
    logic [39:0]        b;
    logic               za, zb, ia, ib, na, nb, sg, g, st, l, inc;
    logic [63:0]        p;
    logic [63:0]        n;
    logic [31:0]        tr;
    logic [32:0]        sum;
    logic [31:0]        m;
    logic signed [10:0] e;
    logic signed [10:0] eb;

    always_comb begin
        // Short format drops the low eight input bits before the product
        a   = fp.short_fmt ? {fp.a[39:8], 8'h00} : fp.a;
        b   = fp.short_fmt ? {fp.b[39:8], 8'h00} : fp.b;
        // Denormals are zero, so they never underflow
        za  = (a[38:31] == 8'h00);
        zb  = (b[38:31] == 8'h00);
        ia  = (a[38:31] == 8'hff) && (a[30:0] == 31'h0);
        ib  = (b[38:31] == 8'hff) && (b[30:0] == 31'h0);
        na  = (a[38:31] == 8'hff) && (a[30:0] != 31'h0);
        nb  = (b[38:31] == 8'hff) && (b[30:0] != 31'h0);
        sg  = a[39] ^ b[39];
        p   = {1'b1, a[30:0]} * {1'b1, b[30:0]};
        n   = p[63] ? p : {p[62:0], 1'b0};
        e   = $signed({3'b000, a[38:31]}) + $signed({3'b000, b[38:31]}) - `MRA_FP_BIAS2
              + (p[63] ? 11'sd1 : 11'sd0);
        g   = fp.short_fmt ? n[39] : n[31];
        st  = fp.short_fmt ? |n[38:0] : |n[30:0];
        l   = fp.short_fmt ? n[40] : n[32];
        // Chop rounds toward zero, otherwise nearest-even
        inc = !fp.chop && g && (st || l);
        tr  = fp.short_fmt ? {n[63:40], 8'h00} : n[63:32];
        sum = {1'b0, tr} + (inc ? (fp.short_fmt ? 33'h100 : 33'h001) : 33'h000);
        m   = sum[32] ? sum[32:1] : sum[31:0];
        eb  = e + (sum[32] ? 11'sd1 : 11'sd0);
        fp.flg = '0;
        fp.res = {sg, eb[7:0] + 8'd127, m[30:0]};
        if (na || nb || (ia && zb) || (ib && za)) begin
            fp.flg.inv = 1'b1;
            fp.res     = 40'h7f_ffff_ffff;
        end else if (ia || ib) begin
            fp.flg.neg = sg;
            fp.res     = {sg, 8'hff, 31'h0};
        end else if (za || zb) begin
            fp.res = {sg, 39'h0};
        end else if (eb > `MRA_FP_EMAX) begin
            fp.flg.ovf = 1'b1;
            fp.flg.neg = sg;
            fp.res     = fp.chop ? {sg, 8'hfe, 31'h7fff_ffff} : {sg, 8'hff, 31'h0};
        end else if (eb < `MRA_FP_EMIN) begin
            fp.flg.unf = 1'b1;
            fp.res     = {sg, 39'h0};
        end else begin
            fp.flg.neg = sg;
        end
        if (fp.short_fmt) begin
            fp.res[7:0] = 8'h00;
        end
    end
endmodule

/* hdl/mra_top.sv */
// Multiplier result accumulators, transfers, clear/round/saturate and flags.
// Assumes an APB master on ref_clk_i and a sequencer issuing one op per cycle.
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`include "mra_consts.svh"
module mra_top #(
    parameter int ADDR_W = 12
) (
    input  wire logic                ref_clk_i,
    input  wire logic                rst_i,
    input  wire logic [ADDR_W-1:0]   paddr_i,
    input  wire logic                psel_i,
    input  wire logic                penable_i,
    input  wire logic                pwrite_i,
    input  wire logic [31:0]         pwdata_i,
    output logic      [31:0]         prdata_o,
    output logic                     pready_o,
    output logic                     pslverr_o,
    input  wire logic                op_valid_i,
    input  wire mra_pkg::mra_op_t    op_i,
    input  wire logic                acc_sel_i,
    input  wire logic                to_rf_i,
    input  wire logic                x_signed_i,
    input  wire logic                y_signed_i,
    input  wire logic                int_fmt_i,
    input  wire logic                round_i,
    input  wire mra_pkg::mra_part_t  part_i,
    input  wire logic [39:0]         x_i,
    input  wire logic [39:0]         y_i,
    output logic      [39:0]         rf_data_o,
    output logic                     rf_valid_o
);
    if (ADDR_W < 4) begin : g_chk
        $error("ADDR_W too narrow for the register map");
    end

    logic [79:0]         acc_q [2];
    logic [31:0]         mode_q;
    logic [31:0]         arith_q;
    logic [31:0]         sticky_q;
    logic [31:0]         prdata_q;
    logic                pready_q;
    logic                pslverr_q;
    logic [39:0]         rf_data_q;
    logic                rf_valid_q;
    logic                phys;
    logic                sgn;
    logic                fx;
    logic                rnd_en;
    logic                acc_we;
    logic                rf_we;
    logic                fl_we;
    logic                ovf_fx;
    logic [79:0]         src;
    logic [79:0]         xe;
    logic [79:0]         ye;
    logic [79:0]         prod;
    logic [79:0]         res;
    logic [39:0]         rf_d;
    logic [31:0]         w;
    mra_pkg::mra_flags_t fl;
    logic                setup;
    logic                wr_en;
    logic [1:0]          wr_idx;

    mra_fpmul_if fpi ();

    mra_fpmul u_fpmul (
        .fp (fpi.unit)
    );

    function automatic logic [1:0] reg_idx(input logic [ADDR_W-1:0] a);
        logic [1:0] r;
        r = 2'h3;
        if (a == ADDR_W'(`MRA_OFS_MODE)) begin
            r = 2'h0;
        end else if (a == ADDR_W'(`MRA_OFS_ARITH)) begin
            r = 2'h1;
        end else if (a == ADDR_W'(`MRA_OFS_STICKY)) begin
            r = 2'h2;
        end
        return r;
    endfunction

    function automatic logic ovf_chk(input logic [79:0] v, input logic s, input logic i);
        if (s) begin
            return i ? !(&v[79:31] || ~|v[79:31]) : !(&v[79:63] || ~|v[79:63]);
        end
        return i ? |v[79:32] : |v[79:64];
    endfunction

    // Signed fractions may underflow from either sign; unsigned only from zero
    function automatic logic unf_chk(input logic [79:0] v, input logic s);
        return ((s && &v[79:32]) || ~|v[79:32]) && |v[31:0];
    endfunction

    function automatic logic [79:0] sat_val(input logic n, input logic s, input logic i);
        logic [79:0] r;
        r = `MRA_UI_MAX;
        if (s && !i) begin
            r = n ? `MRA_SF_NEG : `MRA_SF_POS;
        end else if (s) begin
            r = n ? `MRA_SI_NEG : `MRA_SI_POS;
        end else if (!i) begin
            r = `MRA_UF_MAX;
        end
        return r;
    endfunction

    assign fpi.a         = x_i;
    assign fpi.b         = y_i;
    assign fpi.chop      = mode_q[`MRA_BIT_CHOP];
    assign fpi.short_fmt = mode_q[`MRA_BIT_SHORT];

    // Operation decode; everything here is one compute-slot op per cycle
    always_comb begin
        phys   = acc_sel_i ^ mode_q[`MRA_BIT_BANK];
        src    = acc_q[phys];
        sgn    = x_signed_i | y_signed_i;
        w      = x_i[39:8];
        xe     = x_signed_i ? {{48{w[31]}}, w} : {48'h0, w};
        ye     = y_signed_i ? {{48{y_i[39]}}, y_i[39:8]} : {48'h0, y_i[39:8]};
        prod   = xe * ye;
        if (x_signed_i && y_signed_i && !int_fmt_i) begin
            prod = {prod[78:0], 1'b0};
        end
        res    = src;
        fx     = 1'b0;
        acc_we = 1'b0;
        rf_we  = 1'b0;
        fl_we  = 1'b0;
        fl     = '0;
        rf_d   = 40'h0;
        rnd_en = 1'b0;
        ovf_fx = 1'b0;
        if (op_valid_i) begin
            unique case (op_i)
                mra_pkg::MRA_OP_MUL: begin
                    res = prod;
                    fx  = 1'b1;
                end
                mra_pkg::MRA_OP_MACA: begin
                    res = src + prod;
                    fx  = 1'b1;
                end
                mra_pkg::MRA_OP_MACS: begin
                    res = src - prod;
                    fx  = 1'b1;
                end
                mra_pkg::MRA_OP_SAT, mra_pkg::MRA_OP_RND: begin
                    fx  = 1'b1;
                end
                mra_pkg::MRA_OP_CLR: begin
                    res    = '0;
                    acc_we = 1'b1;
                    fl_we  = 1'b1;
                end
                mra_pkg::MRA_OP_WRP: begin
                    acc_we = 1'b1;
                    fl_we  = 1'b1;
                    case (part_i)
                        mra_pkg::MRA_PART_LO: res[31:0]  = w;
                        mra_pkg::MRA_PART_UP: res[79:32] = {{16{w[31]}}, w};
                        mra_pkg::MRA_PART_OV: res[79:64] = w[15:0];
                        default:              acc_we     = 1'b0;
                    endcase
                end
                mra_pkg::MRA_OP_RDP: begin
                    rf_we = 1'b1;
                    fl_we = 1'b1;
                    case (part_i)
                        mra_pkg::MRA_PART_LO: rf_d = {src[31:0], 8'h00};
                        mra_pkg::MRA_PART_UP: rf_d = {src[63:32], 8'h00};
                        mra_pkg::MRA_PART_OV: rf_d = {{16{src[79]}}, src[79:64], 8'h00};
                        default:              rf_d = 40'h0;
                    endcase
                end
                mra_pkg::MRA_OP_FMUL: begin
                    rf_we = 1'b1;
                    fl_we = 1'b1;
                    fl    = fpi.flg;
                    rf_d  = fpi.res;
                end
                default: begin
                end
            endcase
        end
        if (fx) begin
            // Rounding is ignored for integer formats
            rnd_en = (round_i || op_i == mra_pkg::MRA_OP_RND) && !int_fmt_i;
            if (rnd_en) begin
                res = res + `MRA_RND_HALF;
                res = {res[79:32], 32'h0};
            end
            ovf_fx = ovf_chk(res, sgn, int_fmt_i);
            fl.neg = res[79];
            fl.ovf = ovf_fx;
            fl.unf = !int_fmt_i && unf_chk(res, sgn);
            if (op_i == mra_pkg::MRA_OP_SAT && ovf_fx) begin
                res = sat_val(res[79], sgn, int_fmt_i);
            end
            fl_we  = 1'b1;
            acc_we = !to_rf_i;
            rf_we  = to_rf_i;
            // Fraction keeps 63-32, which alone truncates when not rounding
            rf_d   = int_fmt_i ? {res[31:0], 8'h00} : {res[63:32], 8'h00};
        end
    end

    // Accumulator storage
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_q[0] <= '0;
            acc_q[1] <= '0;
        end else if (acc_we) begin
            acc_q[phys] <= res;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rf_data_q  <= '0;
            rf_valid_q <= 1'b0;
        end else begin
            rf_valid_q <= rf_we;
            if (rf_we) begin
                rf_data_q <= rf_d;
            end
        end
    end

    // Zero-wait slave: ready rises in the access phase after every setup
    assign setup  = psel_i && !penable_i;
    assign wr_en  = psel_i && penable_i && pready_q && pwrite_i && !pslverr_q;
    assign wr_idx = reg_idx(paddr_i);

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && (wr_idx == 2'h3);
            prdata_q  <= '0;
            if (setup && !pwrite_i) begin
                case (wr_idx)
                    2'h0:    prdata_q <= mode_q;
                    2'h1:    prdata_q <= arith_q;
                    2'h2:    prdata_q <= sticky_q;
                    default: prdata_q <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_q <= `MRA_MODE_RST;
        end else if (wr_en && wr_idx == 2'h0) begin
            mode_q <= pwdata_i & `MRA_MODE_MASK;
        end
    end

    // A software write in the op's cycle replaces the flag update
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            arith_q <= `MRA_ARITH_RST;
        end else if (wr_en && wr_idx == 2'h1) begin
            arith_q <= pwdata_i & `MRA_FLAG_MASK;
        end else if (fl_we) begin
            arith_q[`MRA_BIT_INV:`MRA_BIT_NEG] <= fl;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sticky_q <= `MRA_STICKY_RST;
        end else if (wr_en && wr_idx == 2'h2) begin
            sticky_q <= pwdata_i & `MRA_FLAG_MASK;
        end else if (fl_we) begin
            // Only sets here; clears come only from reset or a software write
            sticky_q[`MRA_BIT_FXOVF] <= sticky_q[`MRA_BIT_FXOVF] | (fx & fl.ovf);
            sticky_q[`MRA_BIT_FLOVF] <= sticky_q[`MRA_BIT_FLOVF] | (!fx & fl.ovf);
            sticky_q[`MRA_BIT_UNF]   <= sticky_q[`MRA_BIT_UNF] | (!fx & fl.unf);
            sticky_q[`MRA_BIT_INV]   <= sticky_q[`MRA_BIT_INV] | fl.inv;
        end
    end

    assign prdata_o   = prdata_q;
    assign pready_o   = pready_q;
    assign pslverr_o  = pslverr_q;
    assign rf_data_o  = rf_data_q;
    assign rf_valid_o = rf_valid_q;

    property p_sticky_hold;
        @(posedge ref_clk_i) disable iff (rst_i)
        (sticky_q[`MRA_BIT_INV] && !(wr_en && wr_idx == 2'h2)) |=> sticky_q[`MRA_BIT_INV];
    endproperty
    a_sticky_hold: assert property (p_sticky_hold) else $error("sticky bit lost");
    property p_arith_wins;
        @(posedge ref_clk_i) disable iff (rst_i)
        (wr_en && wr_idx == 2'h1) |=> arith_q == ($past(pwdata_i) & `MRA_FLAG_MASK);
    endproperty
    a_arith_wins: assert property (p_arith_wins) else $error("status write lost");
    property p_flag_next;
        @(posedge ref_clk_i) disable iff (rst_i)
        (op_valid_i && op_i == mra_pkg::MRA_OP_FMUL && !(wr_en && wr_idx == 2'h1))
        |=> arith_q[`MRA_BIT_INV] == $past(fpi.flg.inv);
    endproperty
    a_flag_next: assert property (p_flag_next) else $error("invalid flag late");
    property p_clear_zero;
        @(posedge ref_clk_i) disable iff (rst_i)
        (op_valid_i && op_i == mra_pkg::MRA_OP_CLR) |=> acc_q[$past(phys)] == 80'h0;
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("clear left bits");
    property p_upper_ext;
        @(posedge ref_clk_i) disable iff (rst_i)
        (op_valid_i && op_i == mra_pkg::MRA_OP_WRP && part_i == mra_pkg::MRA_PART_UP)
        |=> acc_q[$past(phys)][79:63] == {17{$past(x_i[39])}};
    endproperty
    a_upper_ext: assert property (p_upper_ext) else $error("upper write not extended");
    property p_zero_fill;
        @(posedge ref_clk_i) disable iff (rst_i)
        (op_valid_i && op_i != mra_pkg::MRA_OP_FMUL && rf_we)
        |=> rf_valid_o && rf_data_o[7:0] == 8'h00;
    endproperty
    a_zero_fill: assert property (p_zero_fill) else $error("low bits not zero");
    property p_sat_range;
        @(posedge ref_clk_i) disable iff (rst_i)
        (op_valid_i && op_i == mra_pkg::MRA_OP_SAT && !to_rf_i && x_signed_i && !int_fmt_i)
        |=> (&acc_q[$past(phys)][79:63] || ~|acc_q[$past(phys)][79:63]);
    endproperty
    a_sat_range: assert property (p_sat_range) else $error("saturate out of range");
    // A status or sticky write in the same cycle wins, so both are excluded
    property p_ovf_sticky;
        @(posedge ref_clk_i) disable iff (rst_i)
        (fx && fl.ovf && !(wr_en && (wr_idx == 2'h1 || wr_idx == 2'h2)))
        |=> arith_q[`MRA_BIT_OVF] && sticky_q[`MRA_BIT_FXOVF];
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("fixed overflow unflagged");
endmodule

/* dv/mra_seq_model.sv */
// Sequencer and register file stand-in for the multiplier result block.
// Assumes one clock; the bench issues one op at a time through issue.
module mra_seq_model (
    input  wire logic        clk_i,
    input  wire logic        rf_valid_i,
    input  wire logic [39:0] rf_data_i,
    output logic      [91:0] req_o,
    output logic      [39:0] rf_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [39:0] rf_q;
    initial req_o = '0;
    assign rf_o = rf_q;
    // File location changes only on a result pulse
    always_ff @(posedge clk_i) begin
        if (rf_valid_i) begin
            rf_q <= rf_data_i;
        end
    end
    // One op per compute slot; operands are inverted once idle so stale data never matches
    task automatic issue(input logic [10:0] c, input logic [39:0] x, input logic [39:0] y);
        @(posedge clk_i);
        req_o <= {1'b1, c, x, y};
        @(posedge clk_i);
        req_o <= {12'h0, ~x, ~y};
        @(posedge clk_i);
        #1;
    endtask
endmodule

/* dv/mra_top_tb_top.sv */
// Self-checking bench for the multiplier result block.
// Assumes the sequencer model drives ops; APB is driven here.
`include "mra_consts.svh"
module mra_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] RM = `MRA_OFS_MODE, RA = `MRA_OFS_ARITH, RS = `MRA_OFS_STICKY;
    localparam mra_pkg::mra_op_t MUL = mra_pkg::MRA_OP_MUL, FMUL = mra_pkg::MRA_OP_FMUL,
        WRP = mra_pkg::MRA_OP_WRP, RDP = mra_pkg::MRA_OP_RDP, CLR = mra_pkg::MRA_OP_CLR,
        RND = mra_pkg::MRA_OP_RND, SAT = mra_pkg::MRA_OP_SAT;
    logic        clk, rst, psel, penable, pwrite, pready, er, rv, se;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, sk;
    logic [91:0] rq;
    logic [39:0] rfd, rf;
    int          bad_count, num_checks;
    mra_top mra_top_i (
        .ref_clk_i(clk), .rst_i(rst), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(er), .op_valid_i(rq[91]), .op_i(mra_pkg::mra_op_t'(rq[90:87])),
        .acc_sel_i(rq[86]), .to_rf_i(rq[85]), .x_signed_i(rq[84]), .y_signed_i(rq[84]),
        .int_fmt_i(rq[83]), .round_i(rq[82]), .part_i(mra_pkg::mra_part_t'(rq[81:80])),
        .x_i(rq[79:40]), .y_i(rq[39:0]), .rf_data_o(rfd), .rf_valid_o(rv)
    );
    mra_seq_model mra_seq_model_i (
        .clk_i(clk), .rf_valid_i(rv), .rf_data_i(rfd), .req_o(rq), .rf_o(rf)
    );
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [39:0] s, input logic [39:0] e);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    // Request held until pready is sampled high, then released
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        r = prdata;
        se = er;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("register", {8'h0, r}, {8'h0, e});
    endtask
    // m packs bank, to file, signed, integer, round and part
    task automatic go(input mra_pkg::mra_op_t o, input logic [6:0] m,
                      input logic [39:0] a, input logic [39:0] b);
        mra_seq_model_i.issue({o, m}, a, b);
    endtask
    task automatic rdp(input logic [6:0] m, input logic [39:0] e);
        go(RDP, m, '0, '0);
        chk("acc part", rf, e);
    endtask
    task automatic frow(input logic [31:0] md, input logic [39:0] a, input logic [39:0] b,
                        input logic [39:0] e, input logic [31:0] st);
        wr(RM, md);
        go(FMUL, 7'h00, a, b);
        sk = sk | (st & 32'h0000_0380);
        chk("float product", rf, e);
        rd(RA, st);
        rd(RS, sk);
    endtask
    // Register write and an overflowing float product land on the same edge
    task automatic race(input logic [11:0] a, input logic [31:0] d);
        fork
            wr(a, d);
            begin
                @(posedge clk);
                go(FMUL, 7'h00, 40'h7180000000, 40'h7180000000);
            end
        join
    endtask
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, sk} = '0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(RM, `MRA_MODE_RST);
        rd(RA, `MRA_ARITH_RST);
        rd(RS, `MRA_STICKY_RST);
        rd(12'h00c, 32'h0);
        chk("slave error", {39'h0, se}, 40'h1);
        wr(RM, 32'hffff_ffff);
        rd(RM, `MRA_MODE_MASK);
        wr(RM, 32'h0);
        go(MUL, 7'h30, 40'h40000000ff, 40'h40000000ee);
        chk("frac", rf, 40'h2000000000);
        go(MUL, 7'h38, 40'h0000000300, 40'h0000000500);
        chk("int", rf, 40'h0000000f00);
        go(MUL, 7'h30, 40'hffffffff00, 40'h0000000100);
        chk("neg", rf, 40'hffffffff00);
        rd(RA, 32'h0000_0140);
        go(WRP, 7'h01, 40'h80000000ab, '0);
        go(WRP, 7'h00, 40'h12345678cd, '0);
        rdp(7'h02, 40'hffffffff00);
        rdp(7'h01, 40'h8000000000);
        rdp(7'h00, 40'h1234567800);
        rd(RA, 32'h0);
        go(WRP, 7'h40, 40'h0000005a00, '0);
        wr(RM, 32'h1 << `MRA_BIT_BANK);
        rdp(7'h00, 40'h0000005a00);
        rdp(7'h40, 40'h1234567800);
        wr(RM, 32'h0);
        go(CLR, 7'h00, '0, '0);
        for (int i = 0; i < 3; i++) rdp(7'(i), 40'h0);
        go(WRP, 7'h00, 40'h8000000000, '0);
        go(WRP, 7'h01, 40'h0000000100, '0);
        rdp(7'h01, 40'h0000000100);
        go(RND, 7'h30, '0, '0);
        chk("round", rf, 40'h0000000200);
        go(RND, 7'h10, '0, '0);
        rdp(7'h00, 40'h0);
        rdp(7'h01, 40'h0000000200);
        go(WRP, 7'h01, 40'h7fffffff00, '0);
        go(WRP, 7'h02, 40'h0000000100, '0);
        go(SAT, 7'h10, '0, '0);
        rd(RA, 32'h0000_0080);
        rd(RS, 32'h0000_0040);
        rdp(7'h02, 40'h0);
        rdp(7'h01, 40'h7fffffff00);
        rdp(7'h00, 40'hffffffff00);
        rd(RS, 32'h0000_0040);
        go(CLR, 7'h40, '0, '0);
        go(mra_pkg::MRA_OP_MACA, 7'h50, 40'h4000000000, 40'h4000000000);
        go(mra_pkg::MRA_OP_MACS, 7'h70, 40'h2000000000, 40'h4000000000);
        chk("mac", rf, 40'h1000000000);
        rdp(7'h41, 40'h2000000000);
        wr(RS, 32'h0);
        frow(32'h0, 40'h4000000000, 40'h4040000000, 40'h40c0000000, 32'h0);
        frow(32'h0, 40'h3fc0000000, 40'h3f80000001, 40'h3fc0000002, 32'h0);
        frow(32'h8000, 40'h3fc0000000, 40'h3f80000001, 40'h3fc0000001, 32'h0);
        frow(32'h10000, 40'h3fc0000000, 40'h3f80000180, 40'h3fc0000200, 32'h0);
        frow(32'h0, 40'h7180000000, 40'h7180000000, 40'h7f80000000, 32'h80);
        frow(32'h0, 40'h0d80000000, 40'h0d80000000, 40'h0, 32'h100);
        frow(32'h0, 40'h7fffffffff, 40'h3f80000000, 40'h7fffffffff, 32'h200);
        frow(32'h0, 40'h7f80000000, 40'h0000000100, 40'h7fffffffff, 32'h200);
        frow(32'h0, 40'hc000000000, 40'h4040000000, 40'hc0c0000000, 32'h40);
        race(RA, 32'h0000_0240);
        rd(RA, 32'h0000_0240);
        rd(RS, sk);
        race(RS, 32'h0);
        rd(RS, 32'h0);
        rd(RA, 32'h0000_0080);
        finish_test();
    end
    initial begin
        #200_000;
        bad_count++;
        finish_test();
    end
endmodule
